// [sim/start_source_model.sv]
`timescale 1ns/10ps
module start_source_model
	import sar_adc_pkg::*;
(
	// Clock and request from the bench
	input wire logic hclk,
	input wire logic fire,
	input wire logic [2:0] which,
	input wire logic eight,
	input wire logic low,
	// Overflows and strobe pin
	output logic timer0_overflow,
	output logic timer2_low_overflow,
	output logic timer2_high_overflow,
	output logic timer2_eight_bit,
	output logic timer3_low_overflow,
	output logic timer3_high_overflow,
	output logic timer3_eight_bit,
	output logic external_convert_strobe
);
	logic [5:0] pulse_q = 6'h00;
	logic [2:0] gap_q = 3'h0;
	// Outputs in one fixed order, strobe last
	assign {timer0_overflow, timer2_low_overflow, timer2_high_overflow} = pulse_q[5:3];
	assign {timer3_low_overflow, timer3_high_overflow, external_convert_strobe} = pulse_q[2:0];
	// Both timers run in the width the bench asks for
	assign timer2_eight_bit = eight;
	assign timer3_eight_bit = eight;
	// One-cycle overflow or a short strobe high per request
	always @(posedge hclk) begin
		pulse_q[5:1] <= 5'h00;
		if (gap_q != 3'h0) gap_q <= gap_q - 3'h1;
		if (gap_q == 3'h1) pulse_q[0] <= 1'b0;
		if (fire && gap_q == 3'h0) begin
			gap_q <= 3'h4;
			case (which)
				SRC_TIMER0: pulse_q[5] <= 1'b1;
				SRC_TIMER2: pulse_q[low ? 4 : 3] <= 1'b1;
				SRC_TIMER3: pulse_q[low ? 2 : 1] <= 1'b1;
				SRC_STROBE: pulse_q[0] <= 1'b1;
				default: pulse_q[0] <= 1'b0;
			endcase
		end
	end
endmodule : start_source_model

// [sim/tb.sv]
`timescale 1ns/10ps
module tb
	import sar_adc_pkg::*;
;
	typedef struct packed {logic [2:0] src; logic eight; logic low; logic f;} row_type;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic fire = 1'b0;
	logic eight = 1'b0;
	logic low = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [2:0] which = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] hrdata;
	logic [9:0] sample = 10'h000;
	logic hreadyout, hresp, t0, t2l, t2h, t2e, t3l, t3h, t3e, stb, done_f, win_f, pwr, gain, bias;
	logic trk, cvt;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	row_type rows [9] = '{'{SRC_SOFTWARE, 1'b0, 1'b0, 1'b1}, '{SRC_TIMER0, 1'b0, 1'b0, 1'b1},
		'{SRC_TIMER2, 1'b1, 1'b1, 1'b1}, '{SRC_TIMER2, 1'b0, 1'b0, 1'b1},
		'{SRC_TIMER2, 1'b0, 1'b1, 1'b0}, '{SRC_TIMER3, 1'b1, 1'b1, 1'b1},
		'{SRC_TIMER3, 1'b0, 1'b0, 1'b1}, '{SRC_TIMER3, 1'b1, 1'b0, 1'b0},
		'{SRC_STROBE, 1'b0, 1'b0, 1'b1}};

	// Design, far side and clock
	sar_adc_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer0_overflow(t0),
		.timer2_low_overflow(t2l), .timer2_high_overflow(t2h), .timer2_eight_bit(t2e),
		.timer3_low_overflow(t3l), .timer3_high_overflow(t3h), .timer3_eight_bit(t3e),
		.external_convert_strobe(stb), .sample_code(sample), .converter_powered(pwr),
		.input_tracking(trk), .converting(cvt), .sar_step(), .gain_half(gain),
		.low_power_bias(bias), .conversion_done_flag(done_f), .window_match_flag(win_f));
	start_source_model src_u (.hclk(hclk), .fire(fire), .which(which), .eight(eight),
		.low(low), .timer0_overflow(t0), .timer2_low_overflow(t2l),
		.timer2_high_overflow(t2h), .timer2_eight_bit(t2e), .timer3_low_overflow(t3l),
		.timer3_high_overflow(t3h), .timer3_eight_bit(t3e), .external_convert_strobe(stb));
	always #4 hclk = ~hclk;

	// Cuts a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			give_verdict();
		end
	end

	// Single-word bus transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	// Control write, then a request to the far side when a timer or strobe is chosen
	task automatic kick(input logic [7:0] ctl);
		bus(1'b1, OFS_CONTROL, {24'h0, ctl});
		if (ctl[2:0] != SRC_SOFTWARE) begin
			which <= ctl[2:0];
			fire <= 1'b1;
			@(posedge hclk);
			fire <= 1'b0;
		end
	endtask : kick

	// One start; done and result compared, then the start guard is let run out
	task automatic conv(input logic [7:0] ctl, input logic [9:0] s, input logic f,
		input logic [31:0] r);
		sample <= s;
		bus(1'b1, OFS_CONTROL, 32'h0);
		@(posedge hclk);
		kick(ctl);
		repeat (3000) if (done_f !== 1'b1) @(posedge hclk);
		chk({31'h0, done_f}, {31'h0, f});
		if (f) rdchk(OFS_RESULT, r);
		repeat (420) @(posedge hclk);
	endtask : conv

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(OFS_CONTROL, 32'h0);
		rdchk(OFS_CONFIG, 32'hF8);
		rdchk(OFS_POWER, 32'h0F);
		rdchk(OFS_TRACK, 32'h1E);
		rdchk(OFS_LESS, 32'hFFFF);
		rdchk(8'h20, 32'h0);
		bus(1'b1, OFS_CONFIG, 32'h01);
		bus(1'b1, OFS_POWER, 32'h8F);
		repeat (2) @(posedge hclk);
		chk({30'h0, gain, bias}, 32'h3);
		bus(1'b1, OFS_CONFIG, 32'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			eight <= rows[i].eight;
			low <= rows[i].low;
			conv(rows[i].src == SRC_SOFTWARE ? 8'h90 : {5'h10, rows[i].src}, 10'h100 + 10'(i),
				rows[i].f, 32'h100 + i);
		end
		$display("test sources done");
		bus(1'b1, OFS_CONTROL, 32'hA0);
		@(posedge hclk);
		chk({31'h0, done_f}, 32'h1);
		bus(1'b1, OFS_CONTROL, 32'h80);
		repeat (2) @(posedge hclk);
		chk({31'h0, done_f}, 32'h0);
		bus(1'b1, OFS_CONFIG, 32'h04);
		bus(1'b1, OFS_GREATER, 32'h40);
		bus(1'b1, OFS_LESS, 32'h80);
		conv(8'h90, 10'h053, 1'b1, 32'h50);
		chk({31'h0, win_f}, 32'h1);
		bus(1'b1, OFS_CONFIG, 32'h00);
		bus(1'b1, OFS_GREATER, 32'h80);
		bus(1'b1, OFS_LESS, 32'h40);
		conv(8'h90, 10'h020, 1'b1, 32'h20);
		chk({31'h0, win_f}, 32'h1);
		conv(8'h90, 10'h060, 1'b1, 32'h60);
		chk({31'h0, win_f}, 32'h0);
		$display("test window done");
		// Track-and-hold modes seen on the core controls
		bus(1'b1, OFS_CONFIG, 32'h02);
		conv(8'h90, 10'h2AA, 1'b1, 32'h2AA);
		bus(1'b1, OFS_CONTROL, 32'h90);
		repeat (2) @(posedge hclk);
		chk({30'h0, trk, cvt}, 32'h2);
		repeat (420) @(posedge hclk);
		bus(1'b1, OFS_CONFIG, 32'h00);
		bus(1'b1, OFS_CONTROL, 32'h90);
		repeat (2) @(posedge hclk);
		chk({30'h0, trk, cvt}, 32'h1);
		repeat (420) @(posedge hclk);
		chk({30'h0, trk, cvt}, 32'h2);
		$display("test tracking done");
		bus(1'b1, OFS_REPEAT, 32'h1);
		for (int k = 0; k < 4; k++) conv(8'h90, 10'h0C8, k == 3, 32'h320);
		conv(8'h50, 10'h3FF, 1'b1, 32'hFFC);
		chk({31'h0, pwr}, 32'h0);
		sample <= 10'h011;
		kick(8'hD0);
		rdchk(OFS_CONTROL, 32'hD0);
		kick(8'hD0);
		repeat (3000) if (done_f !== 1'b1) @(posedge hclk);
		rdchk(OFS_RESULT, 32'h44);
		chk({31'h0, pwr}, 32'h1);
		$display("test burst done");
		give_verdict();
	end
endmodule : tb

// [src/sar_adc_pkg.sv]
package sar_adc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_POWER = 8'h08;
	localparam logic [7:0] OFS_TRACK = 8'h0C;
	localparam logic [7:0] OFS_REPEAT = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_GREATER = 8'h18;
	localparam logic [7:0] OFS_LESS = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_BURST_BIT = 6;
	localparam int CTL_DONE_BIT = 5;
	localparam int CTL_BUSY_BIT = 4;
	localparam int CTL_WINDOW_BIT = 3;
	localparam int CTL_SRC_LSB = 0;
	localparam int CFG_DIV_LSB = 3;
	localparam int CFG_EIGHT_BIT = 2;
	localparam int CFG_LPTRACK_BIT = 1;
	localparam int CFG_GAIN_BIT = 0;
	localparam int PWR_BIAS_BIT = 7;
	localparam int PWR_TIME_LSB = 0;
	localparam int DIV_W = 5;
	localparam int PWR_TIME_W = 4;
	localparam int TRACK_W = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DIV_W-1:0] RST_DIVIDER = 5'h1F;
	localparam logic [PWR_TIME_W-1:0] RST_POWER_TIME = 4'hF;
	localparam logic [TRACK_W-1:0] RST_TRACK_TIME = 6'h1E;
	localparam logic [15:0] RST_GREATER = 16'h0000;
	localparam logic [15:0] RST_LESS = 16'hFFFF;

	// ----------------------------------------------------------------
	// Start sources
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_SOFTWARE = 3'h0;
	localparam logic [2:0] SRC_TIMER0 = 3'h1;
	localparam logic [2:0] SRC_TIMER2 = 3'h2;
	localparam logic [2:0] SRC_TIMER3 = 3'h3;
	localparam logic [2:0] SRC_STROBE = 3'h4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_HZ = 125000000;
	localparam int MAX_RATE_SPS = 300000;
	localparam int BURST_OSC_HZ = 20000000;
	localparam int MIN_CONV_CYCLES = (SYS_CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
	localparam int BURST_DIV_CYCLES = (SYS_CLK_HZ + BURST_OSC_HZ - 1) / BURST_OSC_HZ;
	localparam logic [7:0] LP_TRACK_TICKS = 8'h03;
	localparam logic [7:0] CONV_TICKS_10 = 8'h0A;
	localparam logic [7:0] CONV_TICKS_8 = 8'h08;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_POWERUP = 4'b0010,
		ST_TRACK = 4'b0100,
		ST_CONVERT = 4'b1000
	} seq_state_type;

endpackage : sar_adc_pkg

// [src/sar_adc_sequencer.sv]
// Contract
// - SAR clock divided from system or oscillator
// - Five convert start sources selectable
// - Start code 000 sw, 001-011 timers, 100 strobe
// - Busy high during conversion, low after
// - Busy fall after the final conversion of the repeat count sets done; result valid
// - Hardware sets done; firmware clears it
// - Timer low or high overflow per mode
// - Default mode tracks except while converting
// - Low-power tracking: 3 SAR clocks first
// - Strobe low tracks; rising edge converts
// - Burst accumulates 1 to 64 conversions
// - Enable bit sets idle power between bursts
// - Cold converter waits power-up time first
// - Burst: one start runs repeat count
// - Done only after full repeat count
// - Window compare only after full count
// - Burst tracking from power and track fields
// - Low-power tracking adds 3 SAR clocks
// - Gain select between 1x and 0.5x
// - Eight-bit mode: two fewer clocks, low zero
// - Low-power bias bit cuts bias current
// - Inside window: strictly between thresholds
`timescale 1ns/10ps
module sar_adc_sequencer
	import sar_adc_pkg::*;
#(
	parameter int RES_W = 10,
	parameter int ACC_W = 16
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Start sources
	input wire logic timer0_overflow,
	input wire logic timer2_low_overflow,
	input wire logic timer2_high_overflow,
	input wire logic timer2_eight_bit,
	input wire logic timer3_low_overflow,
	input wire logic timer3_high_overflow,
	input wire logic timer3_eight_bit,
	input wire logic external_convert_strobe,
	// Analog core
	input wire logic [RES_W-1:0] sample_code,
	output logic converter_powered,
	output logic input_tracking,
	output logic converting,
	output logic sar_step,
	output logic gain_half,
	output logic low_power_bias,
	// Status
	output logic conversion_done_flag,
	output logic window_match_flag
);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rd_mux;
	logic addr_ok;
	logic power_enable_q, burst_mode_select_q, done_q, window_q;
	logic [2:0] start_source_field_q;
	logic [DIV_W-1:0] sar_clock_divider_q;
	logic eight_bit_select_q, low_power_tracking_select_q, input_gain_select_q;
	logic low_power_bias_select_q;
	logic [PWR_TIME_W-1:0] power_up_time_q;
	logic [TRACK_W-1:0] burst_tracking_time_q;
	logic [2:0] repeat_code_q;
	logic [ACC_W-1:0] result_q, gt_q, lt_q;
	seq_state_type st_q, st_d;
	logic ctl_wr, sw_start, finish, window_hit;
	logic burst_eff, enable_eff;
	logic [2:0] source_eff;

	assign addr_ok = hsel && htrans[1] && hready;
	assign ctl_wr = wr_pend_q && (wr_addr_q == OFS_CONTROL);
	assign sw_start = ctl_wr && hwdata[CTL_BUSY_BIT]
		&& (hwdata[CTL_SRC_LSB+:3] == SRC_SOFTWARE);

	// A control write acts with the mode it writes, so enable, burst and start go in one write
	assign burst_eff = ctl_wr ? hwdata[CTL_BURST_BIT] : burst_mode_select_q;
	assign enable_eff = ctl_wr ? hwdata[CTL_ENABLE_BIT] : power_enable_q;
	assign source_eff = ctl_wr ? hwdata[CTL_SRC_LSB+:3] : start_source_field_q;

	// Read data picked in the address phase, shown in the data phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr)
			OFS_CONTROL: begin
				rd_mux[CTL_ENABLE_BIT] = power_enable_q;
				rd_mux[CTL_BURST_BIT] = burst_mode_select_q;
				rd_mux[CTL_DONE_BIT] = done_q;
				rd_mux[CTL_BUSY_BIT] = (st_q != ST_IDLE);
				rd_mux[CTL_WINDOW_BIT] = window_q;
				rd_mux[CTL_SRC_LSB+:3] = start_source_field_q;
			end
			OFS_CONFIG: begin
				rd_mux[CFG_DIV_LSB+:DIV_W] = sar_clock_divider_q;
				rd_mux[CFG_EIGHT_BIT] = eight_bit_select_q;
				rd_mux[CFG_LPTRACK_BIT] = low_power_tracking_select_q;
				rd_mux[CFG_GAIN_BIT] = input_gain_select_q;
			end
			OFS_POWER: begin
				rd_mux[PWR_BIAS_BIT] = low_power_bias_select_q;
				rd_mux[PWR_TIME_LSB+:PWR_TIME_W] = power_up_time_q;
			end
			OFS_TRACK: rd_mux[TRACK_W-1:0] = burst_tracking_time_q;
			OFS_REPEAT: rd_mux[2:0] = repeat_code_q;
			OFS_RESULT: rd_mux[ACC_W-1:0] = result_q;
			OFS_GREATER: rd_mux[ACC_W-1:0] = gt_q;
			OFS_LESS: rd_mux[ACC_W-1:0] = lt_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Address phase capture, zero wait state, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr_q <= haddr;
			end
			if (addr_ok && !hwrite) begin
				hrdata <= rd_mux;
			end
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Configuration registers written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			power_enable_q <= 1'b0;
			burst_mode_select_q <= 1'b0;
			start_source_field_q <= SRC_SOFTWARE;
			sar_clock_divider_q <= RST_DIVIDER;
			eight_bit_select_q <= 1'b0;
			low_power_tracking_select_q <= 1'b0;
			input_gain_select_q <= 1'b0;
			low_power_bias_select_q <= 1'b0;
			power_up_time_q <= RST_POWER_TIME;
			burst_tracking_time_q <= RST_TRACK_TIME;
			repeat_code_q <= 3'h0;
			gt_q <= RST_GREATER;
			lt_q <= RST_LESS;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				OFS_CONTROL: begin
					power_enable_q <= hwdata[CTL_ENABLE_BIT];
					burst_mode_select_q <= hwdata[CTL_BURST_BIT];
					start_source_field_q <= hwdata[CTL_SRC_LSB+:3];
				end
				OFS_CONFIG: begin
					sar_clock_divider_q <= hwdata[CFG_DIV_LSB+:DIV_W];
					eight_bit_select_q <= hwdata[CFG_EIGHT_BIT];
					low_power_tracking_select_q <= hwdata[CFG_LPTRACK_BIT];
					input_gain_select_q <= hwdata[CFG_GAIN_BIT];
				end
				OFS_POWER: begin
					low_power_bias_select_q <= hwdata[PWR_BIAS_BIT];
					power_up_time_q <= hwdata[PWR_TIME_LSB+:PWR_TIME_W];
				end
				OFS_TRACK: burst_tracking_time_q <= hwdata[TRACK_W-1:0];
				OFS_REPEAT: repeat_code_q <= hwdata[2:0];
				OFS_GREATER: gt_q <= hwdata[ACC_W-1:0];
				OFS_LESS: lt_q <= hwdata[ACC_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Start source selection
	// ----------------------------------------------------------------
	logic strb_s1_q, strb_s2_q, strb_s3_q;
	logic strobe_rise, start_evt, start_acc;
	logic [9:0] rate_cnt_q;

	// Strobe pin synchroniser plus edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strb_s1_q <= 1'b0;
			strb_s2_q <= 1'b0;
			strb_s3_q <= 1'b0;
		end else begin
			strb_s1_q <= external_convert_strobe;
			strb_s2_q <= strb_s1_q;
			strb_s3_q <= strb_s2_q;
		end
	end
	assign strobe_rise = strb_s2_q && !strb_s3_q;

	// Start multiplexer
	always_comb begin
		case (source_eff)
			SRC_SOFTWARE: start_evt = sw_start;
			SRC_TIMER0: start_evt = timer0_overflow;
			SRC_TIMER2: start_evt = timer2_eight_bit ? timer2_low_overflow
				: timer2_high_overflow;
			SRC_TIMER3: start_evt = timer3_eight_bit ? timer3_low_overflow
				: timer3_high_overflow;
			SRC_STROBE: start_evt = strobe_rise;
			default: start_evt = 1'b0;
		endcase
	end

	// Only taken when idle and the throughput guard has expired
	assign start_acc = start_evt && (st_q == ST_IDLE) && (rate_cnt_q == 10'h000)
		&& (burst_eff || enable_eff);

	// Throughput guard holds conversions under the maximum rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_cnt_q <= 10'h000;
		end else if (start_acc) begin
			rate_cnt_q <= 10'(MIN_CONV_CYCLES - 1);
		end else if (rate_cnt_q != 10'h000) begin
			rate_cnt_q <= rate_cnt_q - 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// SAR clock generation
	// ----------------------------------------------------------------
	logic [2:0] osc_cnt_q;
	logic osc_tick, src_tick, sar_tick, burst_run_q;
	logic [DIV_W-1:0] div_cnt_q;

	assign osc_tick = (osc_cnt_q == 3'(BURST_DIV_CYCLES - 1));
	assign src_tick = burst_run_q ? osc_tick : 1'b1;
	assign sar_tick = src_tick && (div_cnt_q == sar_clock_divider_q);

	// Burst oscillator rate and divider chain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_cnt_q <= 3'h0;
			div_cnt_q <= '0;
		end else begin
			osc_cnt_q <= osc_tick ? 3'h0 : osc_cnt_q + 3'h1;
			if (sar_tick) begin
				div_cnt_q <= '0;
			end else if (src_tick) begin
				div_cnt_q <= div_cnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic [7:0] tick_cnt_q, track_need, conv_need;
	logic [6:0] conv_cnt_q, repeat_need;
	logic lp_run_q, eight_run_q, strobe_run_q, last_conv;
	logic [ACC_W-1:0] acc_q, sample_ext;

	// Repeat count decode, reserved codes take the largest
	always_comb begin
		case (repeat_code_q)
			3'h0: repeat_need = 7'h01;
			3'h1: repeat_need = 7'h04;
			3'h2: repeat_need = 7'h08;
			3'h3: repeat_need = 7'h10;
			3'h4: repeat_need = 7'h20;
			default: repeat_need = 7'h40;
		endcase
	end

	assign track_need = (burst_run_q ? 8'(burst_tracking_time_q) : 8'h00)
		+ (lp_run_q ? LP_TRACK_TICKS : 8'h00);
	assign conv_need = eight_run_q ? CONV_TICKS_8 : CONV_TICKS_10;
	assign last_conv = (conv_cnt_q + 7'h01) >= repeat_need;
	assign sample_ext = ACC_W'({sample_code[RES_W-1:2],
		eight_run_q ? 2'b00 : sample_code[1:0]});

	// Next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (start_acc && burst_eff && !enable_eff) begin
					st_d = ST_POWERUP;
				end else if (start_acc && burst_eff) begin
					st_d = ST_TRACK;
				end else if (start_acc && low_power_tracking_select_q
						&& source_eff != SRC_STROBE) begin
					st_d = ST_TRACK;
				end else if (start_acc) begin
					st_d = ST_CONVERT;
				end
			end
			ST_POWERUP: begin
				if (sar_tick && tick_cnt_q + 8'h01 >= 8'(power_up_time_q)) begin
					st_d = ST_TRACK;
				end
			end
			ST_TRACK: begin
				if (sar_tick && tick_cnt_q + 8'h01 >= track_need) begin
					st_d = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (sar_tick && tick_cnt_q + 8'h01 >= conv_need) begin
					st_d = (burst_run_q && !last_conv) ? ST_TRACK : ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	assign finish = (st_q == ST_CONVERT) && (st_d != ST_CONVERT) && last_conv;

	// State, tick counter and per-sequence settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_IDLE;
			tick_cnt_q <= 8'h00;
			burst_run_q <= 1'b0;
			lp_run_q <= 1'b0;
			eight_run_q <= 1'b0;
			strobe_run_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_d != st_q) begin
				tick_cnt_q <= 8'h00;
			end else if (sar_tick) begin
				tick_cnt_q <= tick_cnt_q + 8'h01;
			end
			if (start_acc) begin
				burst_run_q <= burst_eff;
				lp_run_q <= low_power_tracking_select_q;
				eight_run_q <= eight_bit_select_q;
				strobe_run_q <= (source_eff == SRC_STROBE);
			end
		end
	end

	// Accumulator and conversion count across the repeat series
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= '0;
			conv_cnt_q <= 7'h00;
			result_q <= '0;
		end else if ((st_q == ST_CONVERT) && (st_d != ST_CONVERT)) begin
			if (last_conv) begin
				result_q <= acc_q + sample_ext;
				acc_q <= '0;
				conv_cnt_q <= 7'h00;
			end else begin
				acc_q <= acc_q + sample_ext;
				conv_cnt_q <= conv_cnt_q + 7'h01;
			end
		end
	end

	// Window test on the final accumulated value
	always_comb begin
		if (gt_q > lt_q) begin
			window_hit = ((acc_q + sample_ext) < lt_q)
				|| ((acc_q + sample_ext) > gt_q);
		end else begin
			window_hit = ((acc_q + sample_ext) > gt_q)
				&& ((acc_q + sample_ext) < lt_q);
		end
	end

	// Sticky flags: hardware set wins over a firmware clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_q <= 1'b0;
			window_q <= 1'b0;
		end else begin
			done_q <= finish || (done_q && !(ctl_wr && !hwdata[CTL_DONE_BIT]));
			window_q <= (finish && window_hit)
				|| (window_q && !(ctl_wr && !hwdata[CTL_WINDOW_BIT]));
		end
	end

	// ----------------------------------------------------------------
	// Analog core controls
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			converter_powered <= 1'b0;
			input_tracking <= 1'b0;
			converting <= 1'b0;
			sar_step <= 1'b0;
			gain_half <= 1'b0;
			low_power_bias <= 1'b0;
			conversion_done_flag <= 1'b0;
			window_match_flag <= 1'b0;
		end else begin
			converter_powered <= power_enable_q || (st_d != ST_IDLE);
			if (burst_mode_select_q || burst_run_q) begin
				input_tracking <= (st_d == ST_TRACK);
			end else if (low_power_tracking_select_q) begin
				input_tracking <= (st_d == ST_TRACK) || ((st_d == ST_IDLE)
					&& (start_source_field_q == SRC_STROBE) && !strb_s2_q);
			end else begin
				input_tracking <= power_enable_q && (st_d != ST_CONVERT);
			end
			converting <= (st_d == ST_CONVERT);
			sar_step <= sar_tick && (st_q == ST_CONVERT);
			gain_half <= input_gain_select_q;
			low_power_bias <= low_power_bias_select_q;
			conversion_done_flag <= done_q || finish;
			window_match_flag <= window_q || (finish && window_hit);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence cold_burst_start;
		start_acc && burst_eff && !enable_eff;
	endsequence
	sequence warm_burst_start;
		start_acc && burst_eff && enable_eff;
	endsequence

	start_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start_acc |=> (st_q != ST_IDLE))
		else $error("accepted start did not raise busy");

	done_on_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
		finish |=> done_q && (st_q == ST_IDLE) && conversion_done_flag)
		else $error("final conversion did not set done");

	done_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
		done_q && !ctl_wr |=> done_q)
		else $error("done flag cleared without firmware write");

	cold_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cold_burst_start |=> (st_q == ST_POWERUP) ##1 converter_powered)
		else $error("cold burst start skipped power-up");

	warm_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
		warm_burst_start |=> (st_q == ST_TRACK))
		else $error("warm burst start did not track at once");

	lp_track_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_TRACK) && !burst_run_q && (st_d == ST_CONVERT)
		|-> sar_tick && (tick_cnt_q == 8'h02))
		else $error("low-power tracking not three SAR clocks");

	burst_repeat_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_CONVERT) && (st_d != ST_CONVERT) && burst_run_q && !last_conv
		|=> (st_q == ST_TRACK) && !$rose(done_q))
		else $error("burst stopped before repeat count");

	window_late_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(window_q) |-> $past(finish))
		else $error("window flag set before count complete");

	eight_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		finish && eight_run_q |=> (result_q[1:0] == 2'b00))
		else $error("eight-bit result has nonzero low bits");

	ignore_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(st_q == ST_CONVERT) && start_evt && !(sar_tick) |=> (st_q == ST_CONVERT))
		else $error("start disturbed running conversion");

endmodule : sar_adc_sequencer
